// file: dv/mst_ctrl_model.sv
// Controller model: drives step, direction and resolution select pins.
// Assumes one request pulse at a time; busy stays high until the step is over.
`timescale 1ns/1ps
module mst_ctrl_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Requests from the bench
  input  wire logic go,
  input  wire logic dir_in,
  input  wire logic sel_in,
  // Pins towards the translator
  output logic      step_pin,
  output logic      dir_pin,
  output logic      resolution_select_pin,
  output logic      busy
);
  logic [3:0] cnt;

  // Levels only move while idle, so they never change near a step edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_pin              <= 1'b0;
      dir_pin               <= 1'b0;
      resolution_select_pin <= 1'b0;
      cnt                   <= 4'h0;
    end else if (cnt == 4'h0) begin
      dir_pin               <= dir_in;
      resolution_select_pin <= sel_in;
      if (go) begin
        cnt <= 4'h1;
      end
    end else begin
      // Rise five cycles after the levels settle; high and low three cycles each
      step_pin <= (cnt >= 4'h5) && (cnt < 4'h8);
      cnt      <= (cnt == 4'hb) ? 4'h0 : cnt + 4'h1;
    end
  end

  assign busy = (cnt != 4'h0);
endmodule : mst_ctrl_model

// file: dv/mst_testbench.sv
// Testbench for the translator: register tasks, pin steps through the model.
// Assumes 40 MHz clock and a one-cycle read latency on the register port.
`timescale 1ns/1ps
module testbench;
  import mst_pkg::*;
  logic               clk, rstn, go, dir_in, sel_in, busy;
  logic               step_pin, dir_pin, sel_pin;
  mst_bus_req_t       bus_req;
  logic [DATA_W-1:0]  bus_rdata;
  mst_phase_t         phase;
  logic [ANGLE_W-1:0] step_angle, cur;
  int                 err_count, tests_run, cyc;
  mst_res_t           res_lo [4] = '{RES_HALF, RES_FULL, RES_FULL, RES_HALF};
  mst_res_t           res_hi [4] = '{RES_QUARTER, RES_HALF, RES_QUARTER, RES_EIGHTH};

  mst_translator mst_translator_inst (.clk(clk), .rstn(rstn), .step_pin(step_pin),
    .dir_pin(dir_pin), .resolution_select_pin(sel_pin), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .phase(phase), .step_angle(step_angle));
  mst_ctrl_model mst_ctrl_model_inst (.clk(clk), .rstn(rstn), .go(go), .dir_in(dir_in),
    .sel_in(sel_in), .step_pin(step_pin), .dir_pin(dir_pin),
    .resolution_select_pin(sel_pin), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Cut a hang short; the whole run needs well under 3000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("[FAIL] timeout expected done seen hang");
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(nm, 16'(e), 16'(bus_rdata));
  endtask : rd

  // One pin step; busy covers sync delay and the move itself
  task automatic do_step(input logic d, input logic [ANGLE_W-1:0] e);
    int n;
    n = 0;
    @(posedge clk);
    go     <= 1'b1;
    dir_in <= d;
    @(posedge clk);
    go <= 1'b0;
    #1;
    while (busy === 1'b1 && n < 30) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("step done", 16'h0000, 16'(busy));
    chk("step_angle", 16'(e), 16'(step_angle));
    cur = e;
  endtask : do_step

  // Move the angle by a serial delta taken from the present position
  task automatic go_to(input logic [ANGLE_W-1:0] t);
    wr(OFS_RUN, {2'h0, t - cur});
    cur = t;
  endtask : go_to

  task automatic chk_ph(input logic [5:0] t, input logic as, input logic [5:0] am,
                        input logic bs, input logic [5:0] bm);
    go_to(t);
    repeat (2) @(posedge clk);
    #1;
    chk("phase", 16'({as, am, bs, bm}), 16'(phase));
  endtask : chk_ph

  task automatic set_mode(input logic [1:0] c, input logic s);
    wr(OFS_CFG, {6'h00, c});
    sel_in <= s;
    repeat (5) @(posedge clk);
  endtask : set_mode

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    rstn = 1'b0; bus_req = '0; go = 1'b0; dir_in = 1'b0; sel_in = 1'b0;
    err_count = 0; tests_run = 0; cyc = 0; cur = 6'h00;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    chk("reset angle", 16'h0000, 16'(step_angle));
    chk("reset phase", 16'({1'b0, 6'h00, 1'b0, 6'h3f}), 16'(phase));
    rd(OFS_CFG, 8'h00, "reset cfg");
    rd(OFS_MODE, 8'h01, "mode low");
    $display("test reset done");
    // Every config code with both select levels
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 2; s++) begin
        set_mode(2'(c), 1'(s));
        rd(OFS_CFG, 8'(c), "cfg");
        rd(OFS_MODE, {5'h00, 1'(s), (s == 1) ? res_hi[c] : res_lo[c]}, "mode");
      end
    end
    $display("test decode done");
    set_mode(2'h0, 1'b0);
    do_step(1'b1, 6'h08);
    set_mode(2'h0, 1'b1);
    do_step(1'b1, 6'h0c);
    do_step(1'b0, 6'h08);
    do_step(1'b0, 6'h04);
    do_step(1'b0, 6'h00);
    do_step(1'b0, 6'h3c);
    set_mode(2'h1, 1'b0);
    do_step(1'b1, 6'h08);
    do_step(1'b1, 6'h18);
    do_step(1'b1, 6'h28);
    do_step(1'b1, 6'h38);
    do_step(1'b1, 6'h08);
    do_step(1'b0, 6'h38);
    $display("test grids done");
    set_mode(2'h3, 1'b1);
    go_to(6'h3c);
    do_step(1'b1, 6'h3e);
    do_step(1'b1, 6'h00);
    do_step(1'b0, 6'h3e);
    go_to(6'h3a);
    set_mode(2'h0, 1'b1);
    do_step(1'b1, 6'h3c);
    go_to(6'h3a);
    set_mode(2'h0, 1'b0);
    do_step(1'b1, 6'h00);
    go_to(6'h3a);
    set_mode(2'h1, 1'b0);
    do_step(1'b1, 6'h08);
    rd(OFS_MODE, 8'h08, "mode dir");
    $display("test change done");
    wr(OFS_RUN, 8'h3f);
    rd(OFS_STATUS, 8'h07, "serial minus one");
    wr(OFS_RUN, 8'h3a);
    rd(OFS_STATUS, 8'h01, "serial minus six");
    cur = 6'h01;
    wr(OFS_STATUS, 8'h2a);
    rd(OFS_STATUS, 8'h01, "status read only");
    rd(4'h7, 8'h00, "unmapped");
    rd(OFS_RUN, 8'h00, "run read");
    $display("test serial done");
    chk_ph(6'h00, 1'b0, 6'h00, 1'b0, 6'h3f);
    chk_ph(6'h04, 1'b0, 6'h17, 1'b0, 6'h3a);
    chk_ph(6'h10, 1'b0, 6'h3f, 1'b0, 6'h00);
    chk_ph(6'h14, 1'b0, 6'h3a, 1'b1, 6'h17);
    chk_ph(6'h1c, 1'b0, 6'h17, 1'b1, 6'h3a);
    chk_ph(6'h20, 1'b0, 6'h00, 1'b1, 6'h3f);
    chk_ph(6'h21, 1'b1, 6'h05, 1'b1, 6'h3f);
    chk_ph(6'h30, 1'b1, 6'h3f, 1'b1, 6'h00);
    chk_ph(6'h34, 1'b1, 6'h3a, 1'b0, 6'h17);
    chk_ph(6'h3f, 1'b1, 6'h05, 1'b0, 6'h3f);
    // Park where both phases share the holding current
    go_to(6'h08);
    rd(OFS_STATUS, 8'h08, "park");
    $display("test table done");
    stop_test();
  end
endmodule : testbench

// file: logic/mst_phase_table.sv
// Phase current lookup: step angle number to sign and magnitude per phase.
// Assumes the angle comes from logic on the same clock; output is registered.
`timescale 1ns/1ps
module mst_phase_table
  import mst_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // Angle in, phase drive out
  input  wire logic [ANGLE_W-1:0] angle,
  output mst_phase_t              phase
);

  typedef struct packed {
    mst_phase_t ph;
  } mst_tbl_state_t;

  mst_tbl_state_t st_reg;
  mst_tbl_state_t st_next;

  // One quadrant of magnitude codes, mirrored for the rest of the cycle
  function automatic logic [MAG_W-1:0] quad_mag(input logic [4:0] p);
    case (p)
      5'h00: quad_mag = 6'h00;
      5'h01: quad_mag = 6'h05;
      5'h02: quad_mag = 6'h0b;
      5'h03: quad_mag = 6'h12;
      5'h04: quad_mag = 6'h17;
      5'h05: quad_mag = 6'h1d;
      5'h06: quad_mag = 6'h23;
      5'h07: quad_mag = 6'h28;
      5'h08: quad_mag = 6'h2c;
      5'h09: quad_mag = 6'h30;
      5'h0a: quad_mag = 6'h34;
      5'h0b: quad_mag = 6'h37;
      5'h0c: quad_mag = 6'h3a;
      5'h0d: quad_mag = 6'h3c;
      5'h0e: quad_mag = 6'h3e;
      default: quad_mag = 6'h3f;
    endcase
  endfunction : quad_mag

  // Table walk: odd quadrants swap which phase reads the rising half
  always_comb begin
    logic [4:0] p_up;
    logic [4:0] p_dn;
    p_up = {1'b0, angle[3:0]};
    p_dn = QUAD_SPAN - p_up;
    st_next = st_reg;
    // Phase A is negative only from 33 to 63; the zero-current entry at 32 stays positive
    st_next.ph.a_sign = angle[5] && (angle[4:0] != 5'h00);
    st_next.ph.a_mag  = angle[4] ? quad_mag(p_dn) : quad_mag(p_up);
    st_next.ph.b_sign = (angle >= B_NEG_LOW) && (angle <= B_NEG_HIGH);
    st_next.ph.b_mag  = angle[4] ? quad_mag(p_up) : quad_mag(p_dn);
  end

  // Registered drive; reset shows the reference position
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{ph: '{a_sign: 1'b0, a_mag: 6'h00, b_sign: 1'b0, b_mag: MAG_FULL}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign phase = st_reg.ph;

  AST_REF_POS: assert property (@(posedge clk) disable iff (!rstn)
    (angle == ANGLE_RESET) |=> (phase.a_mag == 6'h00 && phase.b_mag == MAG_FULL
                                && !phase.b_sign))
    else $error("Angle zero does not give full positive phase B");

endmodule : mst_phase_table

// file: logic/mst_translator.sv
// Microstep translator top: pin synchronisers, resolution decode, step
// angle counter, register port and the phase current lookup.
// Assumes step/dir/select pins are asynchronous; register port is on clk.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module mst_translator
  import mst_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // Motion pins from the controller, asynchronous
  input  wire logic               step_pin,
  input  wire logic               dir_pin,
  input  wire logic               resolution_select_pin,
  // Register port
  input  mst_bus_req_t            bus_req,
  output logic [DATA_W-1:0]       bus_rdata,
  // Phase DAC drive and present angle
  output mst_phase_t              phase,
  output logic [ANGLE_W-1:0]      step_angle
);

  // Whole module state
  typedef struct packed {
    logic               step_meta;
    logic               step_sync;
    logic               step_prev;
    logic               dir_meta;
    logic               dir_sync;
    logic               sel_meta;
    logic               sel_sync;
    logic               resolution_cfg_bit_high;
    logic               resolution_cfg_bit_low;
    logic [ANGLE_W-1:0] angle;
    logic [DATA_W-1:0]  rdata;
  } mst_xlat_state_t;

  mst_xlat_state_t st_reg;
  mst_xlat_state_t st_next;

  logic               step_rise;
  logic               run_wr;
  logic [ANGLE_W-1:0] step_delta_field;
  mst_res_t           res_mode;

  // Config bits plus select level choose the pin-step resolution
  function automatic mst_res_t decode_res(input logic hi, input logic lo, input logic sel);
    case ({hi, lo})
      2'b00:   decode_res = sel ? RES_QUARTER : RES_HALF;
      2'b01:   decode_res = sel ? RES_HALF    : RES_FULL;
      2'b10:   decode_res = sel ? RES_QUARTER : RES_FULL;
      default: decode_res = sel ? RES_EIGHTH  : RES_HALF;
    endcase
  endfunction : decode_res

  // Next permitted angle in the commanded sense. Landing on the grid from an
  // off-grid angle makes resolution changes take effect on the next edge.
  function automatic logic [ANGLE_W-1:0] next_angle(input logic [ANGLE_W-1:0] n,
                                                    input mst_res_t           m,
                                                    input logic               fwd);
    logic [ANGLE_W-1:0] grid;
    logic [ANGLE_W-1:0] offs;
    logic [ANGLE_W-1:0] rel;
    logic [ANGLE_W-1:0] base;
    grid = STEP_EIGHTH;
    offs = OFFS_NONE;
    case (m)
      RES_FULL: begin
        grid = GRID_FULL;
        offs = OFFS_FULL;
      end
      RES_HALF: begin
        grid = GRID_HALF;
      end
      RES_QUARTER: begin
        grid = GRID_QUARTER;
      end
      default: begin
        grid = STEP_EIGHTH;
      end
    endcase
    rel  = n - offs;
    base = rel & ~(grid - 6'h01);
    if (m == RES_EIGHTH) begin
      next_angle = fwd ? n + STEP_EIGHTH : n - STEP_EIGHTH;
    end else if (fwd) begin
      next_angle = base + grid + offs;
    end else if (rel == base) begin
      next_angle = base - grid + offs;
    end else begin
      next_angle = base + offs;
    end
  endfunction : next_angle

  // Decoded strobes and pin events; the pin-derived ones read synchronised copies only
  assign step_rise        = st_reg.step_sync && !st_reg.step_prev;
  assign run_wr           = bus_req.wr && (bus_req.addr == OFS_RUN);
  assign step_delta_field = bus_req.wdata[ANGLE_W-1:0];
  assign res_mode         = decode_res(st_reg.resolution_cfg_bit_high,
                                       st_reg.resolution_cfg_bit_low,
                                       st_reg.sel_sync);

  // Next-state logic
  always_comb begin
    logic [ANGLE_W-1:0] ang;
    ang = st_reg.angle;
    st_next = st_reg;

    // Two flip-flops per pin before any logic looks at it
    st_next.step_meta = step_pin;
    st_next.step_sync = st_reg.step_meta;
    st_next.step_prev = st_reg.step_sync;
    st_next.dir_meta  = dir_pin;
    st_next.dir_sync  = st_reg.dir_meta;
    st_next.sel_meta  = resolution_select_pin;
    st_next.sel_sync  = st_reg.sel_meta;

    // Configuration register write
    if (bus_req.wr && bus_req.addr == OFS_CFG) begin
      st_next.resolution_cfg_bit_low  = bus_req.wdata[CFG_LOW_POS];
      st_next.resolution_cfg_bit_high = bus_req.wdata[CFG_HIGH_POS];
    end

    // Serial delta first, ignoring resolution; a same-cycle pin step then
    // moves on from the result so neither event is lost
    if (run_wr) begin
      ang = ang + step_delta_field;
    end
    if (step_rise) begin
      ang = next_angle(ang, res_mode, st_reg.dir_sync);
    end
    st_next.angle = ang;

    // Read data stands only in the cycle after the read strobe
    st_next.rdata = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_CFG: begin
          st_next.rdata[CFG_LOW_POS]  = st_reg.resolution_cfg_bit_low;
          st_next.rdata[CFG_HIGH_POS] = st_reg.resolution_cfg_bit_high;
        end
        OFS_STATUS: begin
          st_next.rdata[ANGLE_W-1:0] = st_reg.angle;
        end
        OFS_MODE: begin
          st_next.rdata[1:0]          = res_mode;
          st_next.rdata[MODE_SEL_POS] = st_reg.sel_sync;
          st_next.rdata[MODE_DIR_POS] = st_reg.dir_sync;
        end
        default: begin
          st_next.rdata = '0;                                // Run and unmapped read zero
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{step_meta: 1'b0, step_sync: 1'b0, step_prev: 1'b0,
                  dir_meta: 1'b0, dir_sync: 1'b0, sel_meta: 1'b0, sel_sync: 1'b0,
                  resolution_cfg_bit_high: CFG_RESET[CFG_HIGH_POS],
                  resolution_cfg_bit_low: CFG_RESET[CFG_LOW_POS],
                  angle: ANGLE_RESET, rdata: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign bus_rdata  = st_reg.rdata;
  assign step_angle = st_reg.angle;

  // Phase current lookup; angle x 5.625 degrees is implied by the table
  mst_phase_table u_table (
    .clk   (clk),
    .rstn  (rstn),
    .angle (st_reg.angle),
    .phase (phase)
  );

  // Helper for assertions: angle one cycle back and the advance since then
  logic [ANGLE_W-1:0] angle_d;
  logic [ANGLE_W-1:0] advance;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      angle_d <= ANGLE_RESET;
    end else begin
      angle_d <= st_reg.angle;
    end
  end
  assign advance = st_reg.angle - angle_d;

  // A pin step with no serial write beside it
  sequence s_pin_step;
    step_rise && !run_wr;
  endsequence

  sequence s_pin_step_fwd;
    s_pin_step ##0 st_reg.dir_sync;
  endsequence

  sequence s_pin_step_rev;
    s_pin_step ##0 !st_reg.dir_sync;
  endsequence

  AST_EIGHTH_MOVE: assert property (@(posedge clk) disable iff (!rstn)
    (s_pin_step ##0 res_mode == RES_EIGHTH) |=>
      (advance == ($past(st_reg.dir_sync) ? STEP_EIGHTH : 6'h3e)))
    else $error("Eighth step did not move by two");

  AST_FULL_GRID: assert property (@(posedge clk) disable iff (!rstn)
    (s_pin_step ##0 res_mode == RES_FULL) |=> (st_reg.angle[3:0] == 4'h8))
    else $error("Full step left the 8/24/40/56 set");

  AST_HALF_GRID: assert property (@(posedge clk) disable iff (!rstn)
    (s_pin_step ##0 res_mode == RES_HALF) |=> (st_reg.angle[2:0] == 3'h0))
    else $error("Half step off a multiple of eight");

  AST_QUARTER_GRID: assert property (@(posedge clk) disable iff (!rstn)
    (s_pin_step ##0 res_mode == RES_QUARTER) |=> (st_reg.angle[1:0] == 2'h0))
    else $error("Quarter step off a multiple of four");

  AST_FWD_NEAREST: assert property (@(posedge clk) disable iff (!rstn)
    (s_pin_step_fwd ##0 res_mode != RES_EIGHTH) |=>
      (advance != 6'h00 && advance <= GRID_FULL))
    else $error("Forward step did not advance by one grid at most");

  AST_REV_NEAREST: assert property (@(posedge clk) disable iff (!rstn)
    (s_pin_step_rev ##0 res_mode != RES_EIGHTH) |=>
      (advance != 6'h00 && advance >= 6'h30))
    else $error("Reverse step did not retreat by one grid at most");

  AST_SERIAL_ADD: assert property (@(posedge clk) disable iff (!rstn)
    (run_wr && !step_rise) |=> (advance == $past(step_delta_field)))
    else $error("Serial delta not added modulo 64");

  AST_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    (!run_wr && !step_rise) |=> $stable(st_reg.angle))
    else $error("Angle moved without a step edge or serial write");

  AST_ONE_EDGE: assert property (@(posedge clk) disable iff (!rstn)
    step_rise |=> !step_rise)
    else $error("One step edge produced two updates");

  AST_RESET_RES: assert property (@(posedge clk) disable iff (!rstn)
    (!st_reg.resolution_cfg_bit_high && !st_reg.resolution_cfg_bit_low) |->
      (res_mode == (st_reg.sel_sync ? RES_QUARTER : RES_HALF)))
    else $error("Default resolution pair is not half/quarter");

  AST_RDATA_ONE: assert property (@(posedge clk) disable iff (!rstn)
    (bus_req.rd && bus_req.addr == OFS_STATUS) |=>
      (bus_rdata == {2'b00, $past(st_reg.angle)}))
    else $error("Status read does not return the angle");

  // Decode pairs written out apart from decode_res, so a slip in the
  // function cannot hide behind an expectation built from it
  AST_DEC_01: assert property (@(posedge clk) disable iff (!rstn)
    (!st_reg.resolution_cfg_bit_high && st_reg.resolution_cfg_bit_low) |->
      (res_mode == (st_reg.sel_sync ? RES_HALF : RES_FULL)))
    else $error("Config 01 does not give full/half");

  AST_DEC_10: assert property (@(posedge clk) disable iff (!rstn)
    (st_reg.resolution_cfg_bit_high && !st_reg.resolution_cfg_bit_low) |->
      (res_mode == (st_reg.sel_sync ? RES_QUARTER : RES_FULL)))
    else $error("Config 10 does not give full/quarter");

  AST_DEC_11: assert property (@(posedge clk) disable iff (!rstn)
    (st_reg.resolution_cfg_bit_high && st_reg.resolution_cfg_bit_low) |->
      (res_mode == (st_reg.sel_sync ? RES_EIGHTH : RES_HALF)))
    else $error("Config 11 does not give half/eighth");

  // Configuration write lands on the next edge
  AST_CFG_WRITE: assert property (@(posedge clk) disable iff (!rstn)
    (bus_req.wr && bus_req.addr == OFS_CFG) |=>
      (st_reg.resolution_cfg_bit_high == $past(bus_req.wdata[CFG_HIGH_POS]) &&
       st_reg.resolution_cfg_bit_low == $past(bus_req.wdata[CFG_LOW_POS])))
    else $error("Config write did not land");

  AST_MODE_READ: assert property (@(posedge clk) disable iff (!rstn)
    (bus_req.rd && bus_req.addr == OFS_MODE) |=> (bus_rdata[1:0] == $past(res_mode)))
    else $error("Mode read does not return the decoded resolution");

  // Wrap in both senses; eighth mode reaches 62 and 0, the ends of its grid
  AST_WRAP_UP: assert property (@(posedge clk) disable iff (!rstn)
    (s_pin_step_fwd ##0 (res_mode == RES_EIGHTH) ##0 (st_reg.angle == 6'h3e)) |=>
      (st_reg.angle == ANGLE_RESET))
    else $error("Forward eighth step did not wrap to zero");

  AST_WRAP_DOWN: assert property (@(posedge clk) disable iff (!rstn)
    (s_pin_step_rev ##0 (res_mode == RES_EIGHTH) ##0 (st_reg.angle == ANGLE_RESET)) |=>
      (st_reg.angle == 6'h3e))
    else $error("Reverse eighth step did not wrap below zero");

  // Forward quarter steps land on the nearest point above, never further
  AST_QUARTER_NEAR: assert property (@(posedge clk) disable iff (!rstn)
    (s_pin_step_fwd ##0 res_mode == RES_QUARTER) |=>
      (advance != 6'h00 && advance <= GRID_QUARTER))
    else $error("Forward quarter step overshot the nearest point");

  // Serial delta ignores the coarse full-step grid
  AST_RUN_FREE: assert property (@(posedge clk) disable iff (!rstn)
    (run_wr && !step_rise && res_mode == RES_FULL) |=>
      (advance == $past(step_delta_field)))
    else $error("Serial delta was bent by the step resolution");

  // Pin rise reaches the edge detector two samples later
  AST_STEP_LAG: assert property (@(posedge clk) disable iff (!rstn)
    $rose(step_pin) |-> ##2 step_rise)
    else $error("Step pin rise did not reach the edge detector in time");

  // Run register is write only; reads give zero
  AST_RUN_READ: assert property (@(posedge clk) disable iff (!rstn)
    (bus_req.rd && bus_req.addr == OFS_RUN) |=> (bus_rdata == '0))
    else $error("Run read did not return zero");

  // Read data stand one cycle only, zero otherwise
  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!rstn)
    (!bus_req.rd) |=> (bus_rdata == '0))
    else $error("Read data stood without a read strobe");

endmodule : mst_translator

// file: pkg/mst_pkg.sv
// Package for the microstep translator: widths, register map, reset values,
// step grids of each resolution, resolution enum and carrier structs.
// Assumes one 40 MHz clock domain and a plain strobe register port.
package mst_pkg;

  // Widths
  localparam int ANGLE_W = 6;
  localparam int MAG_W   = 6;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 4;

  // Register offsets on the strobe port
  localparam logic [ADDR_W-1:0] OFS_CFG    = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RUN    = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_MODE   = 4'h3;

  // Field positions
  localparam int CFG_LOW_POS  = 0;
  localparam int CFG_HIGH_POS = 1;
  localparam int MODE_SEL_POS = 2;
  localparam int MODE_DIR_POS = 3;

  // Reset values
  localparam logic [1:0]         CFG_RESET   = 2'h0;
  localparam logic [ANGLE_W-1:0] ANGLE_RESET = 6'h00;

  // Step grids: spacing and offset of the permitted angle numbers
  localparam logic [ANGLE_W-1:0] GRID_FULL    = 6'h10;
  localparam logic [ANGLE_W-1:0] OFFS_FULL    = 6'h08;
  localparam logic [ANGLE_W-1:0] GRID_HALF    = 6'h08;
  localparam logic [ANGLE_W-1:0] GRID_QUARTER = 6'h04;
  localparam logic [ANGLE_W-1:0] STEP_EIGHTH  = 6'h02;
  localparam logic [ANGLE_W-1:0] OFFS_NONE    = 6'h00;

  // Phase table geometry
  localparam logic [4:0]         QUAD_SPAN  = 5'h10;
  localparam logic [ANGLE_W-1:0] B_NEG_LOW  = 6'h11;
  localparam logic [ANGLE_W-1:0] B_NEG_HIGH = 6'h30;
  localparam logic [MAG_W-1:0]   MAG_FULL   = 6'h3f;

  // Resolution used for pin-driven motion
  typedef enum logic [1:0] {
    RES_FULL,
    RES_HALF,
    RES_QUARTER,
    RES_EIGHTH
  } mst_res_t;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } mst_bus_req_t;

  // Phase DAC drive: sign and magnitude code per phase
  typedef struct packed {
    logic             a_sign;
    logic [MAG_W-1:0] a_mag;
    logic             b_sign;
    logic [MAG_W-1:0] b_mag;
  } mst_phase_t;

endpackage : mst_pkg
